/* File: verilog/dts_pkg.sv */
package dts_pkg;
    // Register byte offsets on the APB slave (all word aligned)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BUF_SEL = 8'h08;
    localparam logic [7:0] OFS_BUF_TUNE = 8'h0c;
    localparam logic [7:0] OFS_BUF_STEP = 8'h10;
    localparam logic [7:0] OFS_BUF_RATE = 8'h14;
    localparam logic [7:0] OFS_ACT_TUNE = 8'h18;
    localparam logic [7:0] OFS_PHASE = 8'h1c;
    localparam logic [7:0] OFS_INST_TUNE = 8'h20;
    localparam logic [7:0] OFS_ACT_CTRL = 8'h24;
    // Control function register fields
    localparam int CTRL_SWEEP_BIT = 0;
    localparam int CTRL_AUTOCLR_BIT = 1;
    localparam int CTRL_PD_LSB = 2;
    localparam int CTRL_PD_W = 4;
    localparam int CTRL_DIV2_BIT = 6;
    localparam int PD_ALL_W = CTRL_PD_W;
    localparam logic [PD_ALL_W-1:0] PD_ALL = 4'hf;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // Divider ratio from system clock to sync clock
    localparam int SYNC_DIV = 8;
    localparam int SYNC_DIV_W = 3;
    localparam int PROFILES = 4;
endpackage

/* File: verilog/dts_sync_div.sv */
`timescale 1ns/100ps
// Divide-by-eight sync clock and its rising-edge tick
module dts_sync_div (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic ce,
    output logic sync_clk_r,
    output logic sync_rise_r
);
    logic [dts_pkg::SYNC_DIV_W-1:0] cnt_r;

    // Free counter; top bit is the 50 percent duty sync clock
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            cnt_r <= '0;
            sync_clk_r <= 1'b0;
            sync_rise_r <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_r + 1'b1;
            sync_clk_r <= cnt_r[dts_pkg::SYNC_DIV_W-1];
            // Tick aligned with the rising edge that leaves this module
            sync_rise_r <= (cnt_r == {1'b0, {(dts_pkg::SYNC_DIV_W-1){1'b1}}});
        end
    end
endmodule

/* File: verilog/dts_core.sv */
`timescale 1ns/100ps
// Contract
// - Single tone output set by a 32-bit tuning word register.
// - 32-bit phase accumulator adds active tuning word every clock.
// - Four stored profiles chosen by two profile select inputs.
// - Frequency changes keep phase; accumulator never reset on change.
// - Sweep adds step word into frequency accumulator plus base word.
// - Rate word counts down at clock/8; 1 gives step per 8 clocks.
// - Step word is signed; negative sweeps downward.
// - Step size is step word times clock over two to 31.
// - Rate word zero halts sweep; controller stops it itself.
// - Base tuning word never modified by sweeping.
// - Autoclear bit forces frequency accumulator to zero.
// - All power-down bits set gives full sleep with clocks gated. Code drops the system clock enable instead; MCLK keeps running.
// - System clock is reference or half of it per bit 6.
// - Sync clock is system clock divided by eight, on a pin.
// - Update strobe high at sync rising edge copies buffer to active.
// - Profile select change acts exactly like an update strobe.
// - All buffer transfers happen on the sync clock edge.
// - Profile selects give bank base; addresses are bank offsets. Code writes tuning words via the OFS_BUF_SEL pointer.
module dts_core #(
    parameter int PHASE_W = 32,
    parameter int NPROF = dts_pkg::PROFILES
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic UPDATE_STROBE,
    input wire logic PROFILE_SELECT_LOW,
    input wire logic PROFILE_SELECT_HIGH,
    output logic DIVIDED_SYNC_CLOCK,
    output logic [PHASE_W-1:0] PHASE_OUT,
    output logic [PHASE_W-1:0] TUNE_OUT,
    output logic SLEEP,
    output logic SAMPLE_EN
);
    localparam int CW = dts_pkg::SYNC_DIV_W;

    logic sync_clk, sync_rise;
    // Input buffer written by software
    logic [31:0] buf_ctrl_r;
    logic [1:0] buf_sel_r;
    logic [PHASE_W-1:0] buf_tune_r [NPROF];
    logic [PHASE_W-1:0] buf_step_r;
    logic [31:0] buf_rate_r;
    // Active registers, loaded only at sync edges
    logic [31:0] act_ctrl_r;
    logic [PHASE_W-1:0] act_tune_r [NPROF];
    logic [PHASE_W-1:0] act_step_r;
    logic [31:0] act_rate_r;
    logic [1:0] ps_r, ps_prev_r;
    logic [PHASE_W-1:0] phase_r, facc_r, inst_tune;
    logic [31:0] rate_cnt_r;
    logic [CW-1:0] div_r;
    logic div2_ph_r, sys_en, sleep_w, sweeping, transfer;
    logic sel_change;
    logic [PHASE_W-1:0] step_scaled;

    dts_sync_div u_div (
        .MCLK(MCLK),
        .SYS_RST(SYS_RST),
        .ce(sys_en), // Divides the system clock, not MCLK
        .sync_clk_r(sync_clk),
        .sync_rise_r(sync_rise)
    );

    // Full sleep needs every power-down bit; gating is by enable, not clock
    // Sync ticks stop as well, so only a reset brings the core back
    assign sleep_w = (act_ctrl_r[dts_pkg::CTRL_PD_LSB +: dts_pkg::PD_ALL_W]
        == dts_pkg::PD_ALL);
    // Half-rate system clock realised as every other reference cycle
    assign sys_en = CLK_EN & ~sleep_w &
        (~act_ctrl_r[dts_pkg::CTRL_DIV2_BIT] | div2_ph_r);
    assign sweeping = act_ctrl_r[dts_pkg::CTRL_SWEEP_BIT] &&
        act_rate_r != 32'h0000_0000;
    // Profile select picks the active bank
    assign inst_tune = act_tune_r[ps_r] + facc_r;
    // Step weighs twice a tuning word unit: scale 2^31 against 2^32
    assign step_scaled = {act_step_r[PHASE_W-2:0], 1'b0};
    // A select change counts as an update strobe
    assign sel_change = {PROFILE_SELECT_HIGH, PROFILE_SELECT_LOW} !=
        ps_prev_r;
    // At half rate the tick spans two cycles; sys_en keeps one transfer
    assign transfer = sync_rise & sys_en & (UPDATE_STROBE | sel_change);

    // Divide-by-2 phase toggle
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            div2_ph_r <= 1'b0;
        else if (CLK_EN)
            div2_ph_r <= ~div2_ph_r;
    end

    // Profile select sampled only on sync rising edge
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ps_r <= 2'h0;
            ps_prev_r <= 2'h0;
        end
        else if (sys_en && sync_rise)
        begin
            ps_r <= {PROFILE_SELECT_HIGH, PROFILE_SELECT_LOW};
            ps_prev_r <= {PROFILE_SELECT_HIGH, PROFILE_SELECT_LOW};
        end
    end

    // APB write side into the input buffer; zero-wait slave
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            buf_ctrl_r <= dts_pkg::CTRL_RST;
            buf_sel_r <= 2'h0;
            buf_step_r <= '0;
            buf_rate_r <= dts_pkg::WORD_RST;
        end
        else if (CLK_EN && PSEL && PENABLE && PWRITE)
        begin
            // Tuning words live in the per-profile loop below
            if (PADDR == dts_pkg::OFS_CTRL)
                buf_ctrl_r <= PWDATA;
            else if (PADDR == dts_pkg::OFS_BUF_SEL)
                buf_sel_r <= PWDATA[1:0];
            else if (PADDR == dts_pkg::OFS_BUF_STEP)
                buf_step_r <= PWDATA[PHASE_W-1:0];
            else if (PADDR == dts_pkg::OFS_BUF_RATE)
                buf_rate_r <= PWDATA;
        end
    end

    // Whole buffer moves to active set on a qualified sync edge
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            act_ctrl_r <= dts_pkg::CTRL_RST;
            act_step_r <= '0;
            act_rate_r <= dts_pkg::WORD_RST;
        end
        else if (CLK_EN && transfer)
        begin
            act_ctrl_r <= buf_ctrl_r;
            act_step_r <= buf_step_r;
            act_rate_r <= buf_rate_r;
        end
    end

    // One buffered and one active tuning word per profile
    for (genvar g = 0; g < NPROF; g++)
    begin : g_prof
        // Buffer entry written through the profile pointer
        always_ff @(posedge MCLK)
        begin
            if (SYS_RST)
                buf_tune_r[g] <= '0;
            else if (CLK_EN && PSEL && PENABLE && PWRITE &&
                PADDR == dts_pkg::OFS_BUF_TUNE && buf_sel_r == 2'(g))
                buf_tune_r[g] <= PWDATA[PHASE_W-1:0];
        end

        // Active entry loads with the rest of the buffer
        always_ff @(posedge MCLK)
        begin
            if (SYS_RST)
                act_tune_r[g] <= '0;
            else if (CLK_EN && transfer)
                act_tune_r[g] <= buf_tune_r[g];
        end
    end

    // Clock/8 prescale for the rate countdown
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            div_r <= '0;
        else if (sys_en)
            div_r <= div_r + 1'b1;
    end

    // Rate countdown and frequency accumulator
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            rate_cnt_r <= 32'h0000_0001;
            facc_r <= '0;
        end
        else if (sys_en)
        begin
            // Autoclear holds the sweep at its start while set
            if (act_ctrl_r[dts_pkg::CTRL_AUTOCLR_BIT])
                facc_r <= '0;
            else if (sweeping && &div_r)
            begin
                if (rate_cnt_r <= 32'h0000_0001)
                begin
                    rate_cnt_r <= act_rate_r;
                    // Signed wrap add; sign rides in the doubled word
                    facc_r <= facc_r + step_scaled;
                end
                else
                    rate_cnt_r <= rate_cnt_r - 32'h0000_0001;
            end
            // Primed so the first expiry after a start steps at once
            else if (!sweeping)
                rate_cnt_r <= 32'h0000_0001;
        end
    end

    // Phase accumulator; never cleared on a frequency change
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            phase_r <= '0;
        else if (sys_en)
            phase_r <= phase_r + inst_tune;
    end

    // Registered outputs
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            TUNE_OUT <= '0;
            SLEEP <= 1'b0;
            SAMPLE_EN <= 1'b0;
            DIVIDED_SYNC_CLOCK <= 1'b0;
        end
        else if (CLK_EN)
        begin
            TUNE_OUT <= inst_tune;
            SLEEP <= sleep_w;
            SAMPLE_EN <= sys_en;
            DIVIDED_SYNC_CLOCK <= sync_clk;
        end
    end

    // Phase seen outside lags the accumulator by one cycle
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            PHASE_OUT <= '0;
        else if (CLK_EN)
            PHASE_OUT <= phase_r;
    end

    // APB read data and answer, one access cycle
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            // Decoded in setup so the data stands in the access cycle
            if (PSEL && !PENABLE)
            begin
                if (PADDR == dts_pkg::OFS_CTRL)
                    PRDATA <= buf_ctrl_r;
                else if (PADDR == dts_pkg::OFS_STATUS)
                    PRDATA <= {27'h0, sweeping, sleep_w, ps_r, sync_clk};
                else if (PADDR == dts_pkg::OFS_BUF_SEL)
                    PRDATA <= {30'h0, buf_sel_r};
                else if (PADDR == dts_pkg::OFS_BUF_TUNE)
                    PRDATA <= 32'(buf_tune_r[buf_sel_r]);
                else if (PADDR == dts_pkg::OFS_BUF_STEP)
                    PRDATA <= 32'(buf_step_r);
                else if (PADDR == dts_pkg::OFS_BUF_RATE)
                    PRDATA <= buf_rate_r;
                else if (PADDR == dts_pkg::OFS_ACT_TUNE)
                    PRDATA <= 32'(act_tune_r[ps_r]);
                else if (PADDR == dts_pkg::OFS_PHASE)
                    PRDATA <= 32'(phase_r);
                else if (PADDR == dts_pkg::OFS_INST_TUNE)
                    PRDATA <= 32'(inst_tune);
                else if (PADDR == dts_pkg::OFS_ACT_CTRL)
                    PRDATA <= act_ctrl_r;
                else
                    PSLVERR <= 1'b1; // Unmapped address
            end
        end
    end
endmodule

/* File: verif/dts_core_asserts.sv */
`timescale 1ns/100ps
// Port-level checks on APB timing, sync divider, phase and sleep
module dts_core_asserts #(
    parameter int PHASE_W = 32
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic DIVIDED_SYNC_CLOCK,
    input wire logic [PHASE_W-1:0] PHASE_OUT,
    input wire logic [PHASE_W-1:0] TUNE_OUT,
    input wire logic SLEEP,
    input wire logic SAMPLE_EN
);
    // Frozen cycles prove nothing, so they disable every check
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST || !CLK_EN);

    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
        else $error("ready without setup");
    ready_single_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    err_with_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error outside access cycle");
    sync_period_a: assert property ($rose(DIVIDED_SYNC_CLOCK) ##1
        (SAMPLE_EN && !SLEEP)[*7] |=> $rose(DIVIDED_SYNC_CLOCK))
        else $error("sync period not eight");
    sync_low_half_a: assert property ($fell(DIVIDED_SYNC_CLOCK) ##1
        (SAMPLE_EN && !SLEEP)[*3] |=> $rose(DIVIDED_SYNC_CLOCK))
        else $error("sync low half not four");
    sample_div_a: assert property (!SAMPLE_EN && !SLEEP ##1 !SLEEP
        |-> SAMPLE_EN)
        else $error("sample enable gap too long");
    phase_add_a: assert property (SAMPLE_EN && !SLEEP |=>
        PHASE_OUT == $past(PHASE_OUT) + $past(TUNE_OUT))
        else $error("phase step wrong");
    sleep_hold_a: assert property (SLEEP && $past(SLEEP) |->
        $stable(PHASE_OUT) && $stable(DIVIDED_SYNC_CLOCK))
        else $error("clocks run in sleep");
endmodule

bind dts_core dts_core_asserts #(.PHASE_W(PHASE_W)) u_dts_core_asserts (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DIVIDED_SYNC_CLOCK(DIVIDED_SYNC_CLOCK), .PHASE_OUT(PHASE_OUT),
    .TUNE_OUT(TUNE_OUT), .SLEEP(SLEEP), .SAMPLE_EN(SAMPLE_EN));

/* File: verif/dts_ctl_model.sv */
`timescale 1ns/100ps
// Outside controller retiming updates and hops to the sync clock
module dts_ctl_model (
    input wire logic MCLK,
    input wire logic sync_clk,
    input wire logic go,
    input wire logic use_strobe,
    input wire logic slow,
    input wire logic [1:0] prof,
    output logic strobe,
    output logic ps_low,
    output logic ps_high,
    output logic busy
);
    logic prev_r;
    logic pend_r;
    logic skip_r;
    initial {strobe, ps_low, ps_high, prev_r, pend_r, skip_r} = '0;
    // Strobe may stand on when the sync clock stops in sleep
    assign busy = pend_r;
    // Change just after a sync rise, so inputs sit still at the next one
    always @(posedge MCLK)
    begin
        prev_r <= sync_clk;
        if (sync_clk && !prev_r)
        begin
            strobe <= 1'b0;
            if (pend_r && slow && !skip_r)
                skip_r <= 1'b1;  // Slow answer: one idle period
            else if (pend_r)
            begin
                strobe <= use_strobe;
                {ps_high, ps_low} <= prof;
                pend_r <= 1'b0;
                skip_r <= 1'b0;
            end
        end
        if (go)
            pend_r <= 1'b1;  // Late so a request is never lost
    end
endmodule

/* File: verif/dts_core_tb.sv */
`timescale 1ns/100ps
module dts_core_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic go = 1'b0;
    logic use_strobe = 1'b1;
    logic slow = 1'b0;
    logic [1:0] prof = 2'h0;
    logic [31:0] prdata, phase, tune, t0, rd;
    logic pready, pslverr, err, dsc, sleep, sample_en;
    logic strobe, ps_low, ps_high, busy;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int k;

    dts_core u_dts_core (.MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(1'b1),
        .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .UPDATE_STROBE(strobe),
        .PROFILE_SELECT_LOW(ps_low), .PROFILE_SELECT_HIGH(ps_high),
        .DIVIDED_SYNC_CLOCK(dsc), .PHASE_OUT(phase), .TUNE_OUT(tune),
        .SLEEP(sleep), .SAMPLE_EN(sample_en));
    dts_ctl_model u_dts_ctl_model (.MCLK(mclk), .sync_clk(dsc), .go(go),
        .use_strobe(use_strobe), .slow(slow), .prof(prof),
        .strobe(strobe), .ps_low(ps_low), .ps_high(ps_high), .busy(busy));

    initial forever #25 mclk = ~mclk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard well above the whole run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    function automatic logic [31:0] tw(input int i);
        return 32'h0123_4567 + 32'h1000_0000 * i;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, waiting for ready however long it takes
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Ask the controller for a transfer and let one sync period pass
    task automatic upd(input logic [1:0] p, input logic s);
        @(posedge mclk);
        prof <= p;
        use_strobe <= s;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (2) @(posedge mclk);
        while (busy !== 1'b0)
            @(posedge mclk);
        repeat (40) @(posedge mclk); // Covers a half-rate sync period
    endtask

    // Sweep step seen over 8 times the rate word
    task automatic swp(input logic [31:0] s, r);
        apb(1, dts_pkg::OFS_BUF_STEP, s);
        apb(1, dts_pkg::OFS_BUF_RATE, r);
        apb(1, dts_pkg::OFS_CTRL, 32'h1);
        upd(2'h0, 1'b1);
        t0 = tune;
        @(posedge mclk);
        while (tune === t0)
            @(posedge mclk);
        t0 = tune;
        repeat (8 * r) @(posedge mclk);
        chk("sweep_step", {s[30:0], 1'b0}, tune - t0);
    endtask

    // Sample enables and sync rises in a 64 cycle window
    task automatic cnt(input logic [31:0] exp_en, exp_rise);
        logic [31:0] e = 0;
        logic [31:0] r = 0;
        logic p = dsc;
        repeat (64)
        begin
            @(posedge mclk);
            e += {31'h0, sample_en};
            r += {31'h0, dsc && !p};
            p = dsc;
        end
        chk("sample_en", exp_en, e);
        chk("sync_rises", exp_rise, r);
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(0, dts_pkg::OFS_ACT_TUNE, 0);
        chk("act_tune", 32'h0, rd);
        apb(0, 8'h80, 0);
        chk("slverr", 32'h1, {31'h0, err});
        for (k = 0; k < 4; k++)
        begin
            apb(1, dts_pkg::OFS_BUF_SEL, k);
            apb(1, dts_pkg::OFS_BUF_TUNE, tw(k));
        end
        chk("tune_pre", 32'h0, tune);
        upd(2'h0, 1'b1);
        chk("tune_p0", tw(0), tune);
        cnt(64, 8);
        $display("profiles loaded done");
        for (k = 1; k < 4; k++)
        begin
            slow <= k[0];
            upd(k[1:0], 1'b0);
            chk("tune_hop", tw(k), tune);
        end
        slow <= 1'b0;
        upd(2'h0, 1'b0);
        $display("hops done");
        swp(32'h0000_0100, 32'h1);
        swp(32'hffff_ffc0, 32'h2);
        apb(0, dts_pkg::OFS_ACT_TUNE, 0);
        chk("base", tw(0), rd);
        apb(1, dts_pkg::OFS_CTRL, 32'h3);
        upd(2'h0, 1'b1);
        chk("autoclear", tw(0), tune);
        apb(1, dts_pkg::OFS_BUF_RATE, 32'h0);
        apb(1, dts_pkg::OFS_CTRL, 32'h1);
        upd(2'h0, 1'b1);
        t0 = tune;
        repeat (40) @(posedge mclk);
        chk("halt", t0, tune);
        $display("sweeps done");
        apb(1, dts_pkg::OFS_CTRL, 32'h40);
        upd(2'h0, 1'b1);
        cnt(32, 4);
        apb(1, dts_pkg::OFS_CTRL, 32'h7c);
        upd(2'h0, 1'b1);
        chk("sleep", 32'h1, {31'h0, sleep});
        t0 = phase;
        repeat (20) @(posedge mclk);
        chk("frozen", t0, phase);
        $display("clocking done");
        give_verdict();
    end
endmodule
